// ===== hw/pot_pkg.sv
// shared constants and types for the potentiometer command executor
package pot_pkg;
  localparam logic [7:0] CMD_WIPER_WRITE = 8'h00;
  localparam logic [7:0] CMD_SHUTDOWN_CLEAR = 8'h80;
  localparam logic [7:0] CMD_SHUTDOWN_HIGH_KEEP_REG = 8'h90;
  localparam logic [7:0] CMD_SHUTDOWN_HIGH_ZERO = 8'h91;
  localparam logic [7:0] CMD_SHUTDOWN_HIGH_MID = 8'h92;
  localparam logic [7:0] CMD_SHUTDOWN_HIGH_FULL = 8'h93;
  localparam logic [7:0] CMD_SHUTDOWN_LOW_KEEP_REG = 8'h88;
  localparam logic [7:0] CMD_SHUTDOWN_LOW_ZERO = 8'h89;
  localparam logic [7:0] CMD_SHUTDOWN_LOW_MID = 8'h8A;
  localparam logic [7:0] CMD_SHUTDOWN_LOW_FULL = 8'h8B;
  localparam logic [7:0] CMD_SHUTDOWN_TAP_TERMINAL = 8'h8C;
  localparam logic [7:0] CMD_CHARGE_PUMP_OFF = 8'hA0;
  localparam logic [7:0] CMD_CHARGE_PUMP_ON = 8'hA1;
  localparam logic [7:0] CMD_RESET = 8'hC0;
  localparam logic [7:0] TAP_ZERO = 8'h00;
  localparam logic [7:0] TAP_MID = 8'h80;
  localparam logic [7:0] TAP_FULL = 8'hFF;
  localparam logic [7:0] WIPER_RESET = 8'h80;
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LAST = 5'h0F;
  // apb map
  localparam logic [11:0] ADDR_WIPER = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CONTROL = 12'h008;
  localparam int ST_PUMP_BIT = 0;
  localparam int ST_SD_ACTIVE_BIT = 1;
  localparam int ST_OPEN_LO_BIT = 4;
  localparam int ST_TAP_LO_BIT = 8;
  localparam int ST_FRAMES_LO_BIT = 16;
  localparam int CTL_IGNORE_BIT = 0;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    SD_NONE = 4'b0000,
    SD_HIGH_KEEP = 4'b0001,
    SD_HIGH_ZERO = 4'b0010,
    SD_HIGH_MID = 4'b0011,
    SD_HIGH_FULL = 4'b0100,
    SD_LOW_KEEP = 4'b0101,
    SD_LOW_ZERO = 4'b0110,
    SD_LOW_MID = 4'b0111,
    SD_LOW_FULL = 4'b1000,
    SD_TAP_TERM = 4'b1001
  } sd_mode_t;

  typedef struct packed {
    logic open_high;
    logic open_low;
    logic open_wiper;
  } terminals_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
  } frame_t;

  typedef struct packed {
    logic csn;
    logic sclk;
    logic din;
  } serial_pins_t;
endpackage : pot_pkg

// ===== hw/pot_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pot_sync3 (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_pin,
  output logic o_level
);
  logic s1;
  logic s2;
  logic s3;
  // first stage feeds only the second; level moves once 2 and 3 agree
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  wire logic agree = (s2 == s3);
  logic lvl_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lvl_q <= 1'b1;
    end else if (agree) begin
      lvl_q <= s3;
    end
  end
  assign o_level = lvl_q;
endmodule : pot_sync3

// ===== hw/pot_shutdown_command_exec.sv
// serial command executor for a 256-tap potentiometer, with apb view
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// Contract
// - shift din on sclk falls while csn low
// - wiper write stores data, moves tap
// - shutdown clear ends shutdown, pump untouched
// - high zero forces tap 0x00
// - high mid forces tap 0x80
// - high full forces tap 0xFF
// - low keep-reg opens low, tap=register
// - low zero forces tap 0x00
// - low mid forces tap 0x80
// - low full forces tap 0xFF
// - tap-terminal shutdown opens wiper, tap=register
// - forced shutdowns keep wiper register intact
// - wiper writes ignored during shutdown
// - clearing restores tap and accepts writes
// - shutdown changes never touch pump enable
// - pump on sets enable, default set
// - pump off clears enable, low power
// - reset restores defaults, cancels shutdown
module pot_shutdown_command_exec
  import pot_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic i_CSN,
  input wire logic i_SCLK,
  input wire logic i_DIN,
  input wire logic i_PSEL,
  input wire logic i_PENABLE,
  input wire logic i_PWRITE,
  input wire logic [11:0] i_PADDR,
  input wire logic [31:0] i_PWDATA,
  output logic [31:0] o_PRDATA,
  output logic o_PREADY,
  output logic o_PSLVERR,
  output logic [7:0] o_TAP,
  output logic o_OPEN_HIGH,
  output logic o_OPEN_LOW,
  output logic o_OPEN_WIPER,
  output logic o_CHARGE_PUMP_EN,
  output logic o_LOW_POWER,
  output logic o_FRAME_DONE
);

  serial_pins_t pins;
  logic csn_lvl;
  logic sclk_lvl;
  logic din_lvl;
  logic sclk_prev;

  pot_sync3 u_sync_csn (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_pin(i_CSN),
    .o_level(csn_lvl)
  );
  pot_sync3 u_sync_sclk (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_pin(i_SCLK),
    .o_level(sclk_lvl)
  );
  pot_sync3 u_sync_din (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_pin(i_DIN),
    .o_level(din_lvl)
  );

  assign pins = '{csn: csn_lvl, sclk: sclk_lvl, din: din_lvl};

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sclk_prev <= 1'b1;
    end else begin
      sclk_prev <= pins.sclk;
    end
  end

  // the divider-free approach relies on sclk at most 1/8 of the core clock
  wire logic sclk_fall = sclk_prev && !pins.sclk;
  wire logic cs_active = !pins.csn;
  wire logic shift_en = cs_active && sclk_fall;

  logic [15:0] shreg;
  logic [4:0] bit_cnt;
  logic frame_pulse;
  logic ignore_serial;

  // a frame cut short by csn rising is dropped, partial bits discarded
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      shreg <= 16'h0000;
      bit_cnt <= 5'h00;
    end else if (!cs_active) begin
      bit_cnt <= 5'h00;
    end else if (shift_en) begin
      shreg <= {shreg[14:0], pins.din};
      bit_cnt <= (bit_cnt == FRAME_LAST) ? 5'h00 : bit_cnt + 5'h01;
    end
  end

  assign frame_pulse = shift_en && (bit_cnt == FRAME_LAST) && !ignore_serial;

  frame_t frame;
  assign frame = '{cmd: shreg[14:7], data: {shreg[6:0], pins.din}};

  logic [7:0] wiper;
  sd_mode_t sd_mode;
  logic pump_en;
  logic [15:0] frame_count;

  function automatic sd_mode_t decode_sd(input logic [7:0] c);
    sd_mode_t m;
    m = SD_NONE;
    if (c == CMD_SHUTDOWN_HIGH_KEEP_REG) begin
      m = SD_HIGH_KEEP;
    end else if (c == CMD_SHUTDOWN_HIGH_ZERO) begin
      m = SD_HIGH_ZERO;
    end else if (c == CMD_SHUTDOWN_HIGH_MID) begin
      m = SD_HIGH_MID;
    end else if (c == CMD_SHUTDOWN_HIGH_FULL) begin
      m = SD_HIGH_FULL;
    end else if (c == CMD_SHUTDOWN_LOW_KEEP_REG) begin
      m = SD_LOW_KEEP;
    end else if (c == CMD_SHUTDOWN_LOW_ZERO) begin
      m = SD_LOW_ZERO;
    end else if (c == CMD_SHUTDOWN_LOW_MID) begin
      m = SD_LOW_MID;
    end else if (c == CMD_SHUTDOWN_LOW_FULL) begin
      m = SD_LOW_FULL;
    end else if (c == CMD_SHUTDOWN_TAP_TERMINAL) begin
      m = SD_TAP_TERM;
    end
    return m;
  endfunction : decode_sd

  wire logic is_wiper_cmd = frame.cmd == CMD_WIPER_WRITE;
  wire logic is_clear_cmd = frame.cmd == CMD_SHUTDOWN_CLEAR;
  wire logic is_reset_cmd = frame.cmd == CMD_RESET;
  wire logic is_pump_on = frame.cmd == CMD_CHARGE_PUMP_ON;
  wire logic is_pump_off = frame.cmd == CMD_CHARGE_PUMP_OFF;
  wire sd_mode_t sd_req = decode_sd(frame.cmd);
  wire logic in_shutdown = sd_mode != SD_NONE;

  logic [7:0] next_wiper;
  sd_mode_t next_sd_mode;
  logic next_pump_en;

  always_comb begin
    next_wiper = wiper;
    next_sd_mode = sd_mode;
    next_pump_en = pump_en;
    if (frame_pulse) begin
      if (is_reset_cmd) begin
        next_wiper = WIPER_RESET;
        next_sd_mode = SD_NONE;
        next_pump_en = 1'b1;
      end else if (is_wiper_cmd) begin
        if (!in_shutdown) begin
          next_wiper = frame.data;
        end
      end else if (is_clear_cmd) begin
        next_sd_mode = SD_NONE;
      end else if (is_pump_on) begin
        next_pump_en = 1'b1;
      end else if (is_pump_off) begin
        next_pump_en = 1'b0;
      end else if (sd_req != SD_NONE) begin
        next_sd_mode = sd_req;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      wiper <= WIPER_RESET;
      sd_mode <= SD_NONE;
      pump_en <= 1'b1;
      frame_count <= 16'h0000;
    end else begin
      wiper <= next_wiper;
      sd_mode <= next_sd_mode;
      pump_en <= next_pump_en;
      if (frame_pulse) begin
        frame_count <= frame_count + 16'h0001;
      end
    end
  end

  // tap position and opened terminal follow the shutdown mode
  logic [7:0] next_tap;
  terminals_t next_term;
  always_comb begin
    next_tap = wiper;
    next_term = '{open_high: 1'b0, open_low: 1'b0, open_wiper: 1'b0};
    case (sd_mode)
      SD_HIGH_KEEP: begin
        next_term.open_high = 1'b1;
      end
      SD_HIGH_ZERO: begin
        next_tap = TAP_ZERO;
        next_term.open_high = 1'b1;
      end
      SD_HIGH_MID: begin
        next_tap = TAP_MID;
        next_term.open_high = 1'b1;
      end
      SD_HIGH_FULL: begin
        next_tap = TAP_FULL;
        next_term.open_high = 1'b1;
      end
      SD_LOW_KEEP: begin
        next_term.open_low = 1'b1;
      end
      SD_LOW_ZERO: begin
        next_tap = TAP_ZERO;
        next_term.open_low = 1'b1;
      end
      SD_LOW_MID: begin
        next_tap = TAP_MID;
        next_term.open_low = 1'b1;
      end
      SD_LOW_FULL: begin
        next_tap = TAP_FULL;
        next_term.open_low = 1'b1;
      end
      SD_TAP_TERM: begin
        next_term.open_wiper = 1'b1;
      end
      default: begin
        next_tap = wiper;
      end
    endcase
  end

  terminals_t term;
  logic [7:0] tap;
  logic done_q;
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      tap <= WIPER_RESET;
      term <= '{open_high: 1'b0, open_low: 1'b0, open_wiper: 1'b0};
      done_q <= 1'b0;
    end else begin
      tap <= next_tap;
      term <= next_term;
      done_q <= frame_pulse;
    end
  end

  assign o_TAP = tap;
  assign o_OPEN_HIGH = term.open_high;
  assign o_OPEN_LOW = term.open_low;
  assign o_OPEN_WIPER = term.open_wiper;
  assign o_CHARGE_PUMP_EN = pump_en;
  assign o_LOW_POWER = !pump_en;
  assign o_FRAME_DONE = done_q;

  // apb slave: zero wait states, unmapped reads zero with pslverr
  logic [31:0] control;
  logic [31:0] prdata;
  wire logic apb_access = i_PSEL && i_PENABLE;
  wire logic hit_wiper = i_PADDR == ADDR_WIPER;
  wire logic hit_status = i_PADDR == ADDR_STATUS;
  wire logic hit_control = i_PADDR == ADDR_CONTROL;
  wire logic hit_any = hit_wiper || hit_status || hit_control;
  wire logic [31:0] status_word = {frame_count, tap, 1'b0,
    term.open_high, term.open_low, term.open_wiper,
    2'b00, in_shutdown, pump_en};
  wire logic [31:0] read_mux = hit_wiper ? {24'h000000, wiper} :
    hit_status ? status_word : hit_control ? control : 32'h0000_0000;

  assign ignore_serial = control[CTL_IGNORE_BIT];

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      control <= CONTROL_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      if (apb_access && i_PWRITE && hit_control) begin
        control <= {31'h00000000, i_PWDATA[CTL_IGNORE_BIT]};
      end
      if (i_PSEL && !i_PENABLE && !i_PWRITE) begin
        prdata <= read_mux;
      end
    end
  end

  assign o_PRDATA = prdata;
  assign o_PREADY = i_PSEL && i_PENABLE;
  assign o_PSLVERR = apb_access && !hit_any;

  chk_write_blocked_sd: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (frame_pulse && is_wiper_cmd && in_shutdown) |=> $stable(wiper))
    else $error("wiper changed during shutdown");

  chk_wiper_write_takes: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (frame_pulse && is_wiper_cmd && !in_shutdown) |=> ##1
      (tap == $past(frame.data, 2)))
    else $error("tap did not follow wiper write");

  sequence s_forced_mid;
    frame_pulse && (frame.cmd == CMD_SHUTDOWN_HIGH_MID ||
      frame.cmd == CMD_SHUTDOWN_LOW_MID);
  endsequence
  chk_mid_forced: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    s_forced_mid |=> ##1 (tap == TAP_MID) && (o_OPEN_HIGH ^ o_OPEN_LOW))
    else $error("midscale shutdown wrong");

  chk_full_forced: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (frame_pulse && (frame.cmd == CMD_SHUTDOWN_HIGH_FULL ||
      frame.cmd == CMD_SHUTDOWN_LOW_FULL)) |=> ##1 (tap == TAP_FULL))
    else $error("fullscale shutdown wrong");

  chk_forced_keeps_reg: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (frame_pulse && sd_req != SD_NONE) |=> $stable(wiper))
    else $error("shutdown altered wiper register");

  chk_clear_restores: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (frame_pulse && is_clear_cmd) |=> ##1 (tap == wiper) &&
      !o_OPEN_HIGH && !o_OPEN_LOW && !o_OPEN_WIPER)
    else $error("clear did not restore");

  chk_pump_stable_sd: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (frame_pulse && (sd_req != SD_NONE || is_clear_cmd)) |=>
      $stable(pump_en))
    else $error("shutdown touched pump");

  chk_pump_cmds: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (frame_pulse && (is_pump_on || is_pump_off)) |=>
      (pump_en == $past(is_pump_on)) && (o_LOW_POWER == !pump_en))
    else $error("pump command wrong");

  chk_reset_defaults: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (frame_pulse && is_reset_cmd) |=> ##1 (tap == WIPER_RESET) &&
      pump_en && !in_shutdown)
    else $error("reset command wrong");

endmodule : pot_shutdown_command_exec

// ===== tb/pot_spi_host.sv
// serial host model that writes command frames into the executor
`timescale 1ns/1ps
module pot_spi_host
  import pot_pkg::*;
(
  input wire logic i_clk,
  output logic o_csn,
  output logic o_sclk,
  output logic o_din
);
  // 13 plus 12 core cycles make the 125 ns link period
  localparam int HALF_HI = 13;
  localparam int HALF_LO = 12;
  localparam int GAP = 50;

  initial begin
    o_csn = 1'b1;
    o_sclk = 1'b1;
    o_din = 1'b0;
  end

  // sclk idles high and stands still between frames
  task automatic send(input frame_t f, input bit abort);
    int n;
    n = abort ? 8 : FRAME_BITS;
    @(posedge i_clk);
    o_csn <= 1'b0;
    for (int i = 0; i < n; i++) begin
      o_din <= f[FRAME_BITS-1-i];
      repeat (HALF_HI) @(posedge i_clk);
      o_sclk <= 1'b0;
      repeat (HALF_LO) @(posedge i_clk);
      o_sclk <= 1'b1;
    end
    repeat (HALF_HI) @(posedge i_clk);
    o_csn <= 1'b1;
    // undriven data line must not look like the last bit
    o_din <= ~o_din;
    repeat (GAP) @(posedge i_clk);
  endtask : send
endmodule : pot_spi_host

// ===== tb/test_pot_shutdown_command_exec.sv
// self-checking bench for the potentiometer command executor
`timescale 1ns/1ps
module test_pot_shutdown_command_exec
  import pot_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, csn, sclk, din;
  logic [7:0] tap;
  logic oh, ol, ow, pump, lp, fdone;
  int failures = 0;
  int num_checks = 0;
  logic [12:0] fq[$];
  logic [32:0] aq[$];
  logic [31:0] rnd = 32'h0001_6EEE;
  logic [7:0] wreg = 8'h80;
  logic [7:0] ftap = 8'h80;
  logic shut = 1'b0;
  logic eh = 1'b0;
  logic el = 1'b0;
  logic ew = 1'b0;
  logic epump = 1'b1;
  int nfr = 0;
  bit fdone_d = 1'b0;
  wire [12:0] st = {tap, oh, ol, ow, pump, lp};

  always #2.5 clk = ~clk;

  pot_shutdown_command_exec u_dut (
    .I_CLK_SYS(clk), .I_RESETN(rstn), .i_CSN(csn), .i_SCLK(sclk),
    .i_DIN(din), .i_PSEL(psel), .i_PENABLE(pen), .i_PWRITE(pwr),
    .i_PADDR(paddr), .i_PWDATA(pwdata), .o_PRDATA(prdata),
    .o_PREADY(pready), .o_PSLVERR(pslverr), .o_TAP(tap),
    .o_OPEN_HIGH(oh), .o_OPEN_LOW(ol), .o_OPEN_WIPER(ow),
    .o_CHARGE_PUMP_EN(pump), .o_LOW_POWER(lp), .o_FRAME_DONE(fdone)
  );

  pot_spi_host u_host (.i_clk(clk), .o_csn(csn), .o_sclk(sclk), .o_din(din));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [32:0] exp_status();
    return {1'b0, nfr[15:0], shut ? ftap : wreg, 1'b0, eh, el, ew,
            2'b00, shut, epump};
  endfunction : exp_status

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic cmp_state(input logic [12:0] e, input logic [12:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH state t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_state

  task automatic cmp_apb(input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH apb t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_apb

  // an unexpected result meets an inverted note and so always fails
  // tap and opens settle one cycle after the done pulse, so look then
  always @(negedge clk) begin
    fdone_d <= (fdone === 1'b1);
    if (fdone_d) begin
      if (fq.size() == 0) fq.push_back(~st);
      cmp_state(fq.pop_front(), st);
    end
    if (psel && pen && pready === 1'b1 && !pwr) begin
      if (aq.size() == 0) aq.push_back(~{pslverr, prdata});
      cmp_apb(aq.pop_front(), {pslverr, prdata});
    end
  end

  task automatic drain();
    int n;
    n = 0;
    while ((fq.size() || aq.size()) && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (fq.size() || aq.size()) begin
      failures++;
      end_sim();
    end
  endtask : drain

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, input logic [32:0] e);
    int n;
    n = 0;
    if (!w) aq.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50) begin
      failures++;
      end_sim();
    end
  endtask : apb

  // reference model of the command set, then one frame on the wire
  task automatic frame(input logic [7:0] c, input logic [7:0] d);
    if (c == CMD_WIPER_WRITE && !shut) wreg = d;
    if (c == CMD_SHUTDOWN_CLEAR || c == CMD_RESET) {shut, eh, el, ew} = 4'h0;
    if (c == CMD_RESET) {wreg, epump} = {WIPER_RESET, 1'b1};
    if (c == CMD_CHARGE_PUMP_OFF) epump = 1'b0;
    if (c == CMD_CHARGE_PUMP_ON) epump = 1'b1;
    if (c inside {[8'h88:8'h8C], [8'h90:8'h93]}) begin
      {shut, eh, el, ew} = {1'b1, c[4], c[3] & ~c[2], c[3] & c[2]};
      ftap = c[1:0] == 2'h0 ? wreg : c[1:0] == 2'h1 ? TAP_ZERO :
             c[1:0] == 2'h2 ? TAP_MID : TAP_FULL;
    end
    fq.push_back({shut ? ftap : wreg, eh, el, ew, epump, ~epump});
    nfr++;
    u_host.send({c, d}, 1'b0);
    drain();
  endtask : frame

  initial begin
    logic [7:0] c;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0, 33'h0_0000_8001);
    apb(1'b0, ADDR_CONTROL, 32'h0, 33'h0);
    apb(1'b0, 12'h00C, 32'h0, 33'h1_0000_0000);
    apb(1'b1, ADDR_WIPER, 32'h55, 33'h0);
    apb(1'b0, ADDR_WIPER, 32'h0, 33'h0_0000_0080);
    for (int i = 0; i < 9; i++) begin
      rnd = xs(rnd);
      c = i < 4 ? 8'h90 + 8'(i) : 8'h84 + 8'(i);
      frame(CMD_WIPER_WRITE, rnd[7:0]);
      frame(i[0] ? CMD_CHARGE_PUMP_OFF : CMD_CHARGE_PUMP_ON, rnd[15:8]);
      frame(c, rnd[23:16]);
      frame(CMD_WIPER_WRITE, ~wreg);
      apb(1'b0, ADDR_WIPER, 32'h0, {25'h0, wreg});
      apb(1'b0, ADDR_STATUS, 32'h0, exp_status());
      frame(CMD_SHUTDOWN_CLEAR, rnd[31:24]);
    end
    frame(CMD_SHUTDOWN_HIGH_FULL, 8'h00);
    frame(CMD_SHUTDOWN_LOW_ZERO, 8'h00);
    frame(CMD_CHARGE_PUMP_OFF, 8'h00);
    frame(CMD_RESET, 8'h00);
    u_host.send({CMD_WIPER_WRITE, 8'h11}, 1'b1);
    frame(CMD_WIPER_WRITE, 8'h3C);
    // frames are dropped while software holds the link off
    apb(1'b1, ADDR_CONTROL, 32'h1, 33'h0);
    apb(1'b0, ADDR_CONTROL, 32'h0, 33'h0_0000_0001);
    u_host.send({CMD_WIPER_WRITE, 8'hC3}, 1'b0);
    apb(1'b0, ADDR_WIPER, 32'h0, 33'h0_0000_003C);
    apb(1'b1, ADDR_CONTROL, 32'h0, 33'h0);
    frame(CMD_WIPER_WRITE, 8'hFF);
    drain();
    apb(1'b0, ADDR_STATUS, 32'h0, exp_status());
    drain();
    end_sim();
  end
endmodule : test_pot_shutdown_command_exec
